// file: verilog/trs_return_stack.sv
// Purpose: Return stack of a trace analyzer inferring suppressed targets
// Assumes: Input elements arrive in order, one per accepted handshake
// Notes:   Result path goes through a two-entry skid buffer
`timescale 1ns/1ps

module trs_return_stack
(
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	input  wire trs_pkg::trs_elem_t i_elem,
	input  wire logic              i_elem_valid,
	output logic                   o_elem_ready,
	output trs_pkg::trs_result_t   o_result,
	output logic                   o_result_valid,
	input  wire logic              i_result_ready,
	output logic [3:0]             o_depth,
	output logic                   o_underflow
);

	////////////////////////////////////////////////////////////////////////////
	// Circular store; oldest slot overwritten on overflow
	trs_pkg::trs_entry_t       mem [trs_pkg::DEPTH];
	logic [3:0]                top;     // index of next free slot
	logic [3:0]                count;
	logic                      pending; // indirect executed, awaiting target
	logic                      last_e_valid;
	logic                      buf_ready;
	logic                      take;
	logic                      do_push;
	logic                      do_pop;
	logic                      emit;
	trs_pkg::trs_result_t      next_result;

	// Index runs over 15 slots, 0 to 14
	function automatic logic [3:0] wrap_inc(input logic [3:0] v);
		wrap_inc = (v == 4'he) ? 4'h0 : v + 4'h1;
	endfunction

	function automatic logic [3:0] wrap_dec(input logic [3:0] v);
		wrap_dec = (v == 4'h0) ? 4'he : v - 4'h1;
	endfunction

	// Taken only while ready shows, so nothing slips in before the first edge after reset
	assign take = i_elem_valid && o_elem_ready;

	assign do_push = take && i_elem.kind == trs_pkg::TRS_EL_ATOM_E && i_elem.is_link;

	// Any waypoint element while pending closes the window without a target
	assign do_pop = take && pending
		&& (i_elem.kind == trs_pkg::TRS_EL_ATOM_E
		|| i_elem.kind == trs_pkg::TRS_EL_ATOM_N
		|| i_elem.kind == trs_pkg::TRS_EL_OTHER_WAYPOINT);

	////////////////////////////////////////////////////////////////////////////
	// Push and pop in one element replace the top slot in place while the stack is not empty
	always_ff @(posedge i_clk)
	begin
		if (do_push && do_pop && count != 4'h0)
		begin
			mem[wrap_dec(top)] <= '{addr: i_elem.link_addr, subset: i_elem.subset};
		end
		else if (do_push)
		begin
			mem[top] <= '{addr: i_elem.link_addr, subset: i_elem.subset};
		end
	end

	// Pointer and occupancy; a mispredict never touches them
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			top   <= trs_pkg::CNT_RESET;
			count <= trs_pkg::CNT_RESET;
		end
		else if (do_pop && count != 4'h0)
		begin
			// Element that closed the window may itself push
			if (do_push)
			begin
				top <= top;
			end
			else
			begin
				top   <= wrap_dec(top);
				count <= count - 4'h1;
			end
		end
		else if (do_push)
		begin
			top <= wrap_inc(top);
			if (count != trs_pkg::CNT_FULL - 4'h0 && count < 4'(trs_pkg::DEPTH))
			begin
				count <= count + 4'h1;
			end
		end
	end

	// Pending indirect waypoint tracking
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pending <= 1'b0;
		end
		else if (take)
		begin
			unique case (i_elem.kind)
				trs_pkg::TRS_EL_TARGET:
					pending <= 1'b0;
				trs_pkg::TRS_EL_ATOM_E:
					pending <= i_elem.is_indirect;
				trs_pkg::TRS_EL_ATOM_N, trs_pkg::TRS_EL_OTHER_WAYPOINT:
					pending <= 1'b0;
				trs_pkg::TRS_EL_MISPREDICT:
					pending <= 1'b0;
				default:
					pending <= pending;
			endcase
		end
	end

	// Most recent executed atom, so a mispredict can flip it
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			last_e_valid <= 1'b0;
		end
		else if (take)
		begin
			if (i_elem.kind == trs_pkg::TRS_EL_ATOM_E)
			begin
				last_e_valid <= 1'b1;
			end
			else if (i_elem.kind == trs_pkg::TRS_EL_MISPREDICT)
			begin
				last_e_valid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_result              = '0;
		next_result.found        = do_pop && count != 4'h0;
		next_result.underflow    = do_pop && count == 4'h0;
		next_result.atom_cleared = take && i_elem.kind == trs_pkg::TRS_EL_MISPREDICT
			&& last_e_valid;
		if (next_result.found)
		begin
			next_result.entry = mem[wrap_dec(top)];
		end
	end

	assign emit = next_result.found || next_result.underflow || next_result.atom_cleared;

	////////////////////////////////////////////////////////////////////////////
	// Two-entry skid buffer: a receiver stall loses no result
	trs_pkg::trs_result_t      slot [2];
	logic                      rd_ptr;
	logic                      wr_ptr;
	logic [1:0]                fill;
	logic                      pop_buf;
	logic [1:0]                next_fill;
	logic                      next_rd;

	assign buf_ready = fill != 2'h2;
	assign pop_buf   = o_result_valid && i_result_ready;
	// Occupancy and head after this edge
	assign next_fill = fill + 2'((take && emit) ? 1 : 0) - 2'(pop_buf ? 1 : 0);
	assign next_rd   = pop_buf ? ~rd_ptr : rd_ptr;

	always_ff @(posedge i_clk)
	begin
		if (take && emit)
		begin
			slot[wr_ptr] <= next_result;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			fill   <= 2'h0;
		end
		else
		begin
			if (take && emit)
			begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop_buf)
			begin
				rd_ptr <= ~rd_ptr;
			end
			fill <= next_fill;
		end
	end

	// Registered outputs
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_result       <= '0;
			o_result_valid <= 1'b0;
			o_elem_ready   <= 1'b0;
			o_depth        <= trs_pkg::CNT_RESET;
			o_underflow    <= 1'b0;
		end
		else
		begin
			o_result_valid <= next_fill != 2'h0;
			if (next_fill == 2'h0)
			begin
				o_result <= '0;
			end
			else if (fill == 2'h0 || (fill == 2'h1 && pop_buf))
			begin
				o_result <= next_result;
			end
			else
			begin
				o_result <= slot[next_rd];
			end
			o_elem_ready <= next_fill != 2'h2;
			o_depth      <= count;
			o_underflow  <= next_result.underflow && take;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stack occupancy, underflow and mispredict reporting
	a_depth_bound: assert property (@(posedge i_clk) disable iff (!i_resetn)
		count <= 4'(trs_pkg::DEPTH))
		else $error("stack count above depth");
	a_push_grows: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(do_push && !do_pop && count < trs_pkg::CNT_FULL) |=> count == $past(count) + 4'h1)
		else $error("push did not grow stack");
	a_full_stays: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(do_push && !do_pop && count == trs_pkg::CNT_FULL) |=> count == trs_pkg::CNT_FULL)
		else $error("full push changed count");
	a_pop_shrinks: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(do_pop && !do_push && count != 4'h0) |=> count == $past(count) - 4'h1)
		else $error("pop did not shrink stack");
	a_mispredict_keeps: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(take && i_elem.kind == trs_pkg::TRS_EL_MISPREDICT) |=> $stable(count))
		else $error("mispredict altered stack");
	a_empty_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(do_pop && count == 4'h0) |=> o_underflow)
		else $error("empty pop not flagged");
	a_empty_nofound: assert property (@(posedge i_clk) disable iff (!i_resetn)
		next_result.underflow |-> !next_result.found)
		else $error("empty pop gave target");
	a_flip_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(take && i_elem.kind == trs_pkg::TRS_EL_ATOM_E) ##1
		(take && i_elem.kind == trs_pkg::TRS_EL_MISPREDICT) |-> next_result.atom_cleared)
		else $error("mispredict not reported");

	// Handshake, buffer, outputs, swap, pending window and mispredict top
	a_ready_mirror: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!buf_ready |-> !o_elem_ready)
		else $error("ready high with buffer full");
	a_result_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(o_result_valid && !i_result_ready) |=> o_result_valid && $stable(o_result))
		else $error("stalled result changed");
	a_result_follows: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(take && emit) |=> o_result_valid)
		else $error("result not offered");
	a_depth_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> o_depth == $past(count))
		else $error("depth output lags");
	a_swap_keeps: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(do_push && do_pop && count != 4'h0) |=> $stable(count))
		else $error("swap changed count");
	a_pending_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(take && i_elem.kind == trs_pkg::TRS_EL_TARGET) |=> !pending)
		else $error("target left window open");
	a_leave_stack: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(take && i_elem.kind == trs_pkg::TRS_EL_MISPREDICT) |=> top == $past(top))
		else $error("mispredict moved top");
	a_underflow_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_underflow |-> $past(next_result.underflow))
		else $error("stray underflow pulse");

endmodule

// file: verilog/trs_pkg.sv
// Purpose: Shared types and constants for the trace return stack
// Assumes: Element stream already decoded and speculation-resolved
// Notes:   Widths fixed; no software-visible registers
package trs_pkg;

	localparam int unsigned ADDR_W    = 64;
	localparam int unsigned SUBSET_W  = 2;
	localparam int unsigned DEPTH     = 15;
	localparam int unsigned CNT_W     = 4;
	localparam logic [3:0]  CNT_RESET = 4'h0;
	localparam logic [3:0]  CNT_FULL  = 4'hf;

	// Element kinds that reach the stack
	typedef enum logic [2:0]
	{
		TRS_EL_NONE,
		TRS_EL_ATOM_E,
		TRS_EL_ATOM_N,
		TRS_EL_TARGET,
		TRS_EL_MISPREDICT,
		TRS_EL_OTHER_WAYPOINT
	} trs_kind_t;

	// One incoming element
	typedef struct packed
	{
		trs_kind_t            kind;
		logic                 is_link;
		logic                 is_indirect;
		logic [ADDR_W-1:0]    link_addr;
		logic [SUBSET_W-1:0]  subset;
	} trs_elem_t;

	// One stack entry
	typedef struct packed
	{
		logic [ADDR_W-1:0]    addr;
		logic [SUBSET_W-1:0]  subset;
	} trs_entry_t;

	// One inferred result
	typedef struct packed
	{
		logic                 found;
		logic                 underflow;
		logic                 atom_cleared;
		trs_entry_t           entry;
	} trs_result_t;

endpackage

// file: sim/trs_elem_source.sv
// Purpose: Element stream model of the trace unit after speculation resolution
// Assumes: The design takes an element at a rising edge while its ready is high
// Notes:   Released data shows the inverse of the last word, so stale data never matches
`timescale 1ns/1ps

module trs_elem_source
(
	input  wire logic          i_clk,
	input  wire logic          i_ready,
	output trs_pkg::trs_elem_t o_elem,
	output logic               o_valid
);
	initial
	begin
		o_elem  = '0;
		o_valid = 1'b0;
	end

	// Ends an offer; the caller runs it before letting another edge pass
	task automatic quiet();
		if (o_valid)
		begin
			o_valid = 1'b0;
			o_elem  = ~o_elem;
		end
	endtask

	// Called just after an edge; returns just after the edge that took the element,
	// still offering it, so back-to-back sends never lower and raise valid at once
	task automatic send(input trs_pkg::trs_elem_t e, input int gap);
		if (gap > 0)
			quiet();
		repeat (gap)
		begin
			@(posedge i_clk);
			#1;
		end
		o_elem  = e;
		o_valid = 1'b1;
		while (!i_ready)
		begin
			@(posedge i_clk);
			#1;
		end
		@(posedge i_clk);
		#1;
	endtask
endmodule

// file: sim/tb_trs_return_stack.sv
// Purpose: Self-checking bench of the trace return stack
// Assumes: Elements come from the source model; results are drained here
// Notes:   The receiver stalls during the overflow run so the buffer refuses
`timescale 1ns/1ps

module tb_trs_return_stack;
	logic                 i_clk;
	logic                 i_resetn;
	logic                 i_result_ready;
	logic                 elem_valid;
	logic                 elem_ready;
	logic                 res_valid;
	logic                 underflow;
	logic                 uf_seen;
	logic [3:0]           depth;
	trs_pkg::trs_elem_t   elem;
	trs_pkg::trs_result_t result;
	trs_pkg::trs_result_t rq[$];
	trs_pkg::trs_result_t r;
	int                   miscompares;
	int                   n_tests;

	trs_return_stack i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_elem(elem),
		.i_elem_valid(elem_valid), .o_elem_ready(elem_ready), .o_result(result),
		.o_result_valid(res_valid), .i_result_ready(i_result_ready), .o_depth(depth),
		.o_underflow(underflow));
	trs_elem_source i_src (.i_clk(i_clk), .i_ready(elem_ready), .o_elem(elem),
		.o_valid(elem_valid));

	always #12.5 i_clk = ~i_clk;

	always @(posedge i_clk)
	begin
		if (res_valid && i_result_ready)
			rq.push_back(result);
		if (underflow)
			uf_seen <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic trs_pkg::trs_elem_t mk(input trs_pkg::trs_kind_t k, input logic l,
		input logic ind, input logic [63:0] a);
		return '{k, l, ind, a, a[1:0]};
	endfunction

	task automatic pop(input trs_pkg::trs_kind_t k);
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b0, 1'b1, 64'h0), 0);
		i_src.send(mk(k, 1'b0, 1'b0, 64'h0), 0);
	endtask

	task automatic take(output trs_pkg::trs_result_t t);
		int n;
		n = 0;
		i_src.quiet();
		while (rq.size() == 0 && n < 60)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		t = (rq.size() != 0) ? rq.pop_front() : '0;
	endtask

	// Flags are found, underflow, cleared atom, error pulse seen
	task automatic chk_res(input trs_pkg::trs_result_t g, input logic [3:0] f,
		input logic [63:0] a);
		n_tests++;
		if ({g.found, g.underflow, g.atom_cleared, uf_seen} !== f ||
			(f[3] && g.entry !== {a, a[1:0]}))
		begin
			miscompares++;
			$display("ERROR %0t result %h", $time, g);
		end
	endtask

	task automatic chk_dep(input logic [3:0] d);
		i_src.quiet();
		repeat (4) @(posedge i_clk);
		#1;
		n_tests++;
		if (depth !== d || rq.size() != 0)
		begin
			miscompares++;
			$display("ERROR %0t depth %h", $time, depth);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_walk();
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'ha5), 0);
		pop(trs_pkg::TRS_EL_ATOM_N);
		take(r);
		chk_res(r, 4'h8, 64'ha5);
		chk_dep(4'h0);
	endtask

	task automatic t_target();
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'hb7), 2);
		pop(trs_pkg::TRS_EL_TARGET);
		chk_dep(4'h1);
		pop(trs_pkg::TRS_EL_OTHER_WAYPOINT);
		take(r);
		chk_res(r, 4'h8, 64'hb7);
		chk_dep(4'h0);
	endtask

	task automatic t_mispred();
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'hc2), 0);
		i_src.send(mk(trs_pkg::TRS_EL_MISPREDICT, 1'b0, 1'b0, 64'h0), 0);
		take(r);
		chk_res(r, 4'h2, 64'h0);
		chk_dep(4'h1);
		pop(trs_pkg::TRS_EL_ATOM_E);
		take(r);
		chk_res(r, 4'h8, 64'hc2);
	endtask

	task automatic t_swap();
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'hd1), 0);
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b0, 1'b1, 64'h0), 0);
		i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'he6), 0);
		take(r);
		chk_res(r, 4'h8, 64'hd1);
		chk_dep(4'h1);
		pop(trs_pkg::TRS_EL_ATOM_N);
		take(r);
		chk_res(r, 4'h8, 64'he6);
	endtask

	task automatic t_overflow();
		for (int i = 0; i < 17; i++)
			i_src.send(mk(trs_pkg::TRS_EL_ATOM_E, 1'b1, 1'b0, 64'h100 + i), i % 2);
		chk_dep(4'hf);
		i_result_ready = 1'b0;
		fork
			begin
				repeat (15) pop(trs_pkg::TRS_EL_ATOM_N);
				i_src.quiet();
			end
			begin
				repeat (30) @(posedge i_clk);
				#1;
				i_result_ready = 1'b1;
			end
		join
		for (int i = 16; i > 1; i--)
		begin
			take(r);
			chk_res(r, 4'h8, 64'h100 + i);
		end
		pop(trs_pkg::TRS_EL_ATOM_N);
		take(r);
		chk_dep(4'h0);
		chk_res(r, 4'h5, 64'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		i_clk = 1'b0;
		i_resetn = 1'b0;
		i_result_ready = 1'b1;
		uf_seen = 1'b0;
		miscompares = 0;
		n_tests = 0;
		repeat (12) @(posedge i_clk);
		#1;
		i_resetn = 1'b1;
		@(posedge i_clk);
		#1;
		t_walk();
		t_target();
		t_mispred();
		t_swap();
		t_overflow();
		close_out();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#(25 * 5000);
		miscompares++;
		close_out();
	end
endmodule
